/* inc/bsd_regs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef BSD_REGS_SVH
`define BSD_REGS_SVH
// Overview of operation
// R1: shadow 11 plus spare bit frees E8000-EFFFF
// R2: video size 16/32/48/64 KB, reset 16
// R3: layout 00 selects ROM E/F and top
// R4: layout 10 selects F, top, C window
// R5: shared ROM video half seen at C and F
// R6: ROM select is chip-select code 00
// R7: layout codes 128K, 64K reset, shared, reserved
// R8: pointer IRQ choice boosts speed one second
// R9: unmapped E segment DRAM made inaccessible
// R10: remapped E segment goes to expansion bus
// R11: boundary register blocks writes above it
// R12: DMA cycles timed by tuned delay line
// R13: timing register writes apply at once
// R14: mode 00 one-clock hold, 01 half
// R15: read after write adds one wait
// R16: EMS and interleave miss add wait
// R17: write CAS delay 1.0 to 2.5
// R18: read CAS delay 1.0 to 2.5
// R19: RAS hold after CAS, halved on 1X
// R20: CAS pulse extension in half steps
// R21: added wait states 0 to 3
// R22: precharge is 2(2+ws) minus RAS width
`define BSD_TIM_ADDR 16'h4072
`define BSD_SHD_ADDR 16'h6072
`define BSD_BND_ADDR 16'hc072
`define BSD_TIM_RST 16'h0000
`define BSD_SHD_RST 16'h0004
`define BSD_BND_RST 16'h0000
`define BSD_TIM_MASK 16'h7f7f
`define BSD_SHD_MASK 16'hffbf
`define BSD_BND_MASK 16'h00ff
`define BSD_HMWP_BIT 13
`define BSD_WP_BIT 12
`define BSD_SHD_LSB 8
`define BSD_XMEM_BIT 7
`define BSD_VSZ_LSB 4
`define BSD_ROM_LSB 2
`define BSD_PTR_LSB 0
`define BSD_MODE_LSB 13
`define BSD_RAW_BIT 12
`define BSD_WCAS_LSB 10
`define BSD_RCAS_LSB 8
`define BSD_HLD_LSB 5
`define BSD_PWE_LSB 2
`define BSD_WS_LSB 0
`define BSD_CS_ROM 5'h00
`define BSD_CS_NONE 5'h1f
`define BSD_CLK_KHZ 40000
`define BSD_BOOST_MS 1000
`define BSD_BOOST_CYC (`BSD_BOOST_MS * `BSD_CLK_KHZ)
`define BSD_ROW_UNITS 6'd4
`define BSD_CAS_UNITS 6'd4
`define BSD_DMA_PERIODS 2'd2
`endif

/* inc/bsd_pkg.sv */
// types and shared helpers for the memory map and timing block
`default_nettype none
package bsd_pkg;
    typedef enum logic [2:0] {
        st_idle,
        st_row,
        st_casd,
        st_act,
        st_pre,
        st_wait
    } bsd_state_t;
    // half-step code to core clocks: 1.0 DOUBLE_RATE_CPU_CLOCK = 2 units
    function automatic logic [5:0] bsd_half(input logic [1:0] code);
        return 6'd2 + {4'd0, code};
    endfunction
endpackage
`default_nettype wire

/* design/bsd_map_decode.sv */
// address decode for ROM select, shadow RAM, expansion and write protect
`timescale 1ns/1ps
`default_nettype none
`include "bsd_regs.svh"
module bsd_map_decode (
    input wire logic [24:0] addr,
    input wire logic is_write,
    input wire logic [15:0] shd_reg,
    input wire logic [7:0] bound,
    output logic rom_cs,
    output logic exp_sel,
    output logic dram_sel,
    output logic wr_block
);
    logic [1:0] bios_shadow_select;
    logic [1:0] vsz;
    logic [1:0] rom;
    logic lowmb, seg_c, seg_e, seg_f, top_e, top_f;
    logic vwin, xram, shadow_hit, hi640, remap;
    assign bios_shadow_select = shd_reg[`BSD_SHD_LSB+:2];
    assign vsz = shd_reg[`BSD_VSZ_LSB+:2];
    assign rom = shd_reg[`BSD_ROM_LSB+:2];
    assign lowmb = addr[24:20] == 5'h00;
    assign seg_c = lowmb && addr[19:16] == 4'hc;
    assign seg_e = lowmb && addr[19:16] == 4'he;
    assign seg_f = lowmb && addr[19:16] == 4'hf;
    assign top_e = addr[24:17] == 8'h7f;
    assign top_f = addr[24:16] == 9'h0ff;
    assign hi640 = lowmb && addr[19:17] >= 3'h5;
    // video window grows in 16 KB steps from C0000
    assign vwin = seg_c && addr[15:14] <= vsz; // R2
    // E segment is handed to the expansion bus once video is remapped
    assign remap = bios_shadow_select == 2'b11; // R10
    assign xram = remap && shd_reg[`BSD_XMEM_BIT] && seg_e && addr[15]; // R1
    // shadowed ROM images are served from DRAM
    always_comb begin
        case (bios_shadow_select)
            2'b01: shadow_hit = seg_f;
            2'b10: shadow_hit = seg_e || seg_f;
            2'b11: shadow_hit = seg_f || vwin;
            default: shadow_hit = 1'b0;
        endcase
    end
    // ROM select per layout; reserved layout never selects
    always_comb begin
        case (rom)
            2'b00: rom_cs = (seg_e && !remap) || seg_f || top_e; // R3 R10
            2'b01: rom_cs = seg_f || top_f; // R7
            2'b10: rom_cs = seg_f || top_f || vwin; // R4 R5
            default: rom_cs = 1'b0; // R7
        endcase
        if (shadow_hit) begin
            rom_cs = 1'b0;
        end
    end
    // unmapped E segment falls to the bus, hiding its DRAM
    assign exp_sel = hi640 && !rom_cs && !shadow_hit && !xram; // R9 R10
    assign dram_sel = !rom_cs && !exp_sel;
    assign wr_block = is_write && ((shd_reg[`BSD_HMWP_BIT] && addr[24:17] >= bound) // R11
        || (shd_reg[`BSD_WP_BIT] && shadow_hit));
endmodule
`default_nettype wire

/* design/bsd_ref_tuner.sv */
// measures the reference clock period to tune the DMA delay line
`timescale 1ns/1ps
`default_nettype none
module bsd_ref_tuner (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ref_in,
    output logic [3:0] tune
);
    logic ref_q;
    logic [3:0] cnt_q, cnt_d, tune_q, tune_d;
    logic rise;
    assign rise = ref_in && !ref_q;
    assign tune = tune_q;
    // period in core clocks, saturating so a stopped reference is harmless
    always_comb begin
        cnt_d = cnt_q;
        tune_d = tune_q;
        if (rise) begin
            tune_d = (cnt_q == 4'h0) ? 4'h1 : cnt_q; // R12
            cnt_d = 4'h1;
        end else if (cnt_q != 4'hf) begin
            cnt_d = cnt_q + 4'h1;
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_q <= 1'b0;
            cnt_q <= 4'h0;
            tune_q <= 4'h3;
        end else begin
            ref_q <= ref_in;
            cnt_q <= cnt_d;
            tune_q <= tune_d;
        end
    end
    AST_TUNE_NONZERO: assert property (@(posedge core_clk) disable iff (!rst_n) tune_q != 4'h0) // R12
        else $error("delay line tune is zero");
endmodule
`default_nettype wire

/* design/bsd_memctl.sv */
// memory map registers and non-page DRAM cycle sequencer
`timescale 1ns/1ps
`default_nettype none
`include "bsd_regs.svh"
module bsd_memctl #(
    parameter int BOOST_CYCLES = `BSD_BOOST_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [15:0] io_wdata,
    output logic [15:0] io_rdata,
    input wire logic mem_start,
    input wire logic [24:0] mem_addr,
    input wire logic mem_write,
    input wire logic mem_dma,
    input wire logic mem_ems,
    input wire logic mem_ilv_miss,
    input wire logic [2:0] pointer_irq,
    input wire logic auto_speed_switch,
    input wire logic reference_14m_clock,
    output logic [4:0] rom_chip_select,
    output logic expansion_select,
    output logic dram_select,
    output logic write_blocked,
    output logic ras_n,
    output logic cas_n,
    output logic cycle_done,
    output logic [2:0] wait_states,
    output logic speed_boost,
    output logic pointer_activity
);
    logic [15:0] tim_q, tim_d, shd_q, shd_d, bnd_q, bnd_d, rdata_q, rdata_d;
    logic dec_rom, dec_exp, dec_dram, dec_block;
    logic [3:0] tune;
    bsd_pkg::bsd_state_t st_q, st_d;
    logic [5:0] cnt_q, cnt_d, rasl_q, rasl_d, casl_q, casl_d;
    logic [5:0] cdl_q, cdl_d, cw_q, cw_d, hold_q, hold_d, pre_q, pre_d;
    logic [2:0] waits_q, waits_d;
    logic [4:0] cs_q, cs_d;
    logic exp_q, exp_d, dram_q, dram_d, blk_q, blk_d;
    logic ras_n_q, ras_n_d, cas_n_q, cas_n_d, done_q, done_d, raw_q, raw_d;
    logic [25:0] boost_q, boost_d;
    logic ptr_hit, act_q, act_d, spd_q, spd_d;
    logic [1:0] cc, ptr;
    logic shrink, pshrink;
    logic [5:0] cdl_c, cw_c, hold_c, rasw_c, pref_c;
    logic [2:0] waits_c;

    bsd_map_decode u_dec (
        .addr(mem_addr),
        .is_write(mem_write),
        .shd_reg(shd_q),
        .bound(bnd_q[7:0]),
        .rom_cs(dec_rom),
        .exp_sel(dec_exp),
        .dram_sel(dec_dram),
        .wr_block(dec_block)
    );

    bsd_ref_tuner u_tune (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ref_in(reference_14m_clock),
        .tune(tune)
    );

    // i/o port registers; reads return masked contents a cycle later
    always_comb begin
        tim_d = tim_q;
        shd_d = shd_q;
        bnd_d = bnd_q;
        rdata_d = rdata_q;
        if (io_wr) begin
            case (io_addr)
                `BSD_TIM_ADDR: tim_d = io_wdata & `BSD_TIM_MASK; // R13
                `BSD_SHD_ADDR: shd_d = io_wdata & `BSD_SHD_MASK;
                `BSD_BND_ADDR: bnd_d = io_wdata & `BSD_BND_MASK; // R11
                default: tim_d = tim_q;
            endcase
        end
        if (io_rd) begin
            case (io_addr)
                `BSD_TIM_ADDR: rdata_d = tim_q;
                `BSD_SHD_ADDR: rdata_d = shd_q;
                `BSD_BND_ADDR: rdata_d = bnd_q;
                default: rdata_d = 16'h0000;
            endcase
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tim_q <= `BSD_TIM_RST;
            shd_q <= `BSD_SHD_RST; // R2 R7
            bnd_q <= `BSD_BND_RST;
            rdata_q <= 16'h0000;
        end else begin
            tim_q <= tim_d;
            shd_q <= shd_d;
            bnd_q <= bnd_d;
            rdata_q <= rdata_d;
        end
    end

    // cycle timing from the live register, so a write counts on the next cycle
    always_comb begin
        cc = mem_write ? tim_q[`BSD_WCAS_LSB+:2] : tim_q[`BSD_RCAS_LSB+:2]; // R17 R18
        shrink = cc[1]; // R19
        pshrink = mem_write ? tim_q[`BSD_WCAS_LSB] : tim_q[`BSD_RCAS_LSB+1]; // R20
        cdl_c = bsd_pkg::bsd_half(cc);
        // mode 01 trims row hold by half a clock before a read CAS
        if (tim_q[`BSD_MODE_LSB] && !mem_write) begin
            cdl_c = cdl_c - 6'd1; // R14
        end
        hold_c = bsd_pkg::bsd_half(tim_q[`BSD_HLD_LSB+:2]) - {5'd0, shrink}; // R19
        cw_c = `BSD_CAS_UNITS + {3'd0, tim_q[`BSD_PWE_LSB+:3]} - {5'd0, pshrink}; // R20
        rasw_c = cdl_c + hold_c;
        pref_c = {2'b00, tim_q[`BSD_WS_LSB+:2], 2'b00} + 6'd8; // R22
        // negative or zero precharge clamps to one cycle
        pref_c = (pref_c > rasw_c) ? pref_c - rasw_c : 6'd1; // R22
        waits_c = {2'b00, !tim_q[`BSD_MODE_LSB]} + {1'b0, tim_q[`BSD_WS_LSB+:2]} // R14 R21
            + {2'b00, raw_q && !mem_write && !tim_q[`BSD_RAW_BIT]} // R15
            + {2'b00, mem_ems || mem_ilv_miss}; // R16
        if (mem_dma) begin
            cdl_c = {tune, 2'b00} >> 1; // R12
            cw_c = cdl_c;
            hold_c = cdl_c;
            waits_c = 3'd0;
        end
    end

    // sequencer: row setup, CAS delay, active, precharge, waits
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        rasl_d = rasl_q;
        casl_d = casl_q;
        cdl_d = cdl_q;
        cw_d = cw_q;
        hold_d = hold_q;
        pre_d = pre_q;
        waits_d = waits_q;
        cs_d = cs_q;
        exp_d = exp_q;
        dram_d = dram_q;
        blk_d = blk_q;
        ras_n_d = ras_n_q;
        cas_n_d = cas_n_q;
        done_d = 1'b0;
        raw_d = raw_q;
        case (st_q)
            bsd_pkg::st_idle: begin
                if (mem_start) begin
                    cs_d = dec_rom ? `BSD_CS_ROM : `BSD_CS_NONE; // R6
                    exp_d = dec_exp;
                    dram_d = dec_dram && !dec_block;
                    blk_d = dec_block; // R11
                    cdl_d = cdl_c;
                    cw_d = cw_c;
                    hold_d = hold_c;
                    pre_d = pref_c;
                    waits_d = waits_c;
                    if (dec_dram && !dec_block) begin
                        raw_d = mem_write;
                        if (mem_dma) begin
                            ras_n_d = 1'b0; // R12
                            cnt_d = cdl_c;
                            st_d = bsd_pkg::st_casd;
                        end else begin
                            cnt_d = `BSD_ROW_UNITS;
                            st_d = bsd_pkg::st_row;
                        end
                    end else begin
                        done_d = 1'b1;
                    end
                end
            end
            bsd_pkg::st_row: begin
                cnt_d = cnt_q - 6'd1;
                if (cnt_q == 6'd1) begin
                    ras_n_d = 1'b0;
                    cnt_d = cdl_q;
                    st_d = bsd_pkg::st_casd;
                end
            end
            bsd_pkg::st_casd: begin
                cnt_d = cnt_q - 6'd1;
                if (cnt_q == 6'd1) begin
                    cas_n_d = 1'b0; // R17 R18
                    rasl_d = hold_q;
                    casl_d = cw_q;
                    st_d = bsd_pkg::st_act;
                end
            end
            bsd_pkg::st_act: begin
                if (rasl_q != 6'd0) begin
                    rasl_d = rasl_q - 6'd1;
                end
                if (casl_q != 6'd0) begin
                    casl_d = casl_q - 6'd1;
                end
                if (rasl_q == 6'd1) begin
                    ras_n_d = 1'b1; // R19
                end
                if (casl_q == 6'd1) begin
                    cas_n_d = 1'b1; // R20
                end
                if (rasl_q <= 6'd1 && casl_q <= 6'd1) begin
                    ras_n_d = 1'b1;
                    cas_n_d = 1'b1;
                    cnt_d = pre_q;
                    st_d = bsd_pkg::st_pre;
                end
            end
            bsd_pkg::st_pre: begin
                cnt_d = cnt_q - 6'd1;
                if (cnt_q == 6'd1) begin
                    if (waits_q == 3'd0) begin
                        done_d = 1'b1;
                        st_d = bsd_pkg::st_idle;
                    end else begin
                        // one wait state is one processor clock, four units
                        cnt_d = {1'b0, waits_q, 2'b00}; // R21
                        st_d = bsd_pkg::st_wait;
                    end
                end
            end
            bsd_pkg::st_wait: begin
                cnt_d = cnt_q - 6'd1;
                if (cnt_q == 6'd1) begin
                    done_d = 1'b1;
                    st_d = bsd_pkg::st_idle;
                end
            end
            default: st_d = bsd_pkg::st_idle;
        endcase
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= bsd_pkg::st_idle;
            cnt_q <= 6'd0;
            rasl_q <= 6'd0;
            casl_q <= 6'd0;
            cdl_q <= 6'd0;
            cw_q <= 6'd0;
            hold_q <= 6'd0;
            pre_q <= 6'd0;
            waits_q <= 3'd0;
            cs_q <= `BSD_CS_NONE;
            exp_q <= 1'b0;
            dram_q <= 1'b0;
            blk_q <= 1'b0;
            ras_n_q <= 1'b1;
            cas_n_q <= 1'b1;
            done_q <= 1'b0;
            raw_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            rasl_q <= rasl_d;
            casl_q <= casl_d;
            cdl_q <= cdl_d;
            cw_q <= cw_d;
            hold_q <= hold_d;
            pre_q <= pre_d;
            waits_q <= waits_d;
            cs_q <= cs_d;
            exp_q <= exp_d;
            dram_q <= dram_d;
            blk_q <= blk_d;
            ras_n_q <= ras_n_d;
            cas_n_q <= cas_n_d;
            done_q <= done_d;
            raw_q <= raw_d;
        end
    end

    // pointer interrupt select and one-second speed boost
    assign ptr = shd_q[`BSD_PTR_LSB+:2];
    always_comb begin
        case (ptr)
            2'b01: ptr_hit = pointer_irq[0]; // R8
            2'b10: ptr_hit = pointer_irq[1];
            2'b11: ptr_hit = pointer_irq[2];
            default: ptr_hit = 1'b0;
        endcase
        act_d = ptr_hit;
        boost_d = (boost_q != 26'd0) ? boost_q - 26'd1 : 26'd0;
        if (ptr_hit && auto_speed_switch) begin
            boost_d = 26'(BOOST_CYCLES); // R8
        end
        spd_d = boost_d != 26'd0;
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            boost_q <= 26'd0;
            act_q <= 1'b0;
            spd_q <= 1'b0;
        end else begin
            boost_q <= boost_d;
            act_q <= act_d;
            spd_q <= spd_d;
        end
    end

    assign io_rdata = rdata_q;
    assign rom_chip_select = cs_q;
    assign expansion_select = exp_q;
    assign dram_select = dram_q;
    assign write_blocked = blk_q;
    assign ras_n = ras_n_q;
    assign cas_n = cas_n_q;
    assign cycle_done = done_q;
    assign wait_states = waits_q;
    assign speed_boost = spd_q;
    assign pointer_activity = act_q;

    // checks
    sequence s_start;
        mem_start && st_q == bsd_pkg::st_idle;
    endsequence
    sequence s_ras_then_cas5;
        cas_n_q [*5] ##1 !cas_n_q;
    endsequence
    AST_E_REMAP_BUS: assert property (@(posedge core_clk) disable iff (!rst_n) // R10
        s_start and (mem_addr[24:16] == 9'h00e && shd_q[9:8] == 2'b11 && !shd_q[7]) |=> exp_q && cs_q != `BSD_CS_ROM)
        else $error("remapped E segment not sent to bus");
    AST_ROM_TOP_L0: assert property (@(posedge core_clk) disable iff (!rst_n) // R3
        s_start and (mem_addr[24:17] == 8'h7f && shd_q[3:2] == 2'b00) |=> cs_q == `BSD_CS_ROM)
        else $error("top ROM not selected in layout 00");
    AST_HM_BLOCK: assert property (@(posedge core_clk) disable iff (!rst_n) // R11
        s_start and (mem_write && shd_q[13] && mem_addr[24:17] >= bnd_q[7:0]) |=> blk_q ##1 ras_n_q)
        else $error("write above boundary not blocked");
    AST_RCAS_DELAY: assert property (@(posedge core_clk) disable iff (!rst_n) // R18
        $fell(ras_n_q) && cdl_q == 6'd5 |-> s_ras_then_cas5)
        else $error("CAS delay of five units not kept");
    AST_CAS_WIDTH4: assert property (@(posedge core_clk) disable iff (!rst_n) // R20
        $fell(cas_n_q) && cw_q == 6'd4 |-> !cas_n_q [*4] ##1 cas_n_q)
        else $error("CAS width of four units not kept");
    AST_RAW_WAIT: assert property (@(posedge core_clk) disable iff (!rst_n) // R15
        s_start and (raw_q && !mem_write && !mem_dma && !mem_ems && !mem_ilv_miss && tim_q[14:12] == 3'b000
        && tim_q[1:0] == 2'b00) |=> waits_q == 3'd2)
        else $error("read after write wait missing");
    AST_PRE_HIGH: assert property (@(posedge core_clk) disable iff (!rst_n) // R22
        st_q == bsd_pkg::st_pre |-> ras_n_q && cas_n_q)
        else $error("RAS low during precharge");
    AST_DONE_BOUND: assert property (@(posedge core_clk) disable iff (!rst_n) // R21
        s_start |-> ##[1:200] done_q)
        else $error("cycle did not finish");
    AST_BOOST: assert property (@(posedge core_clk) disable iff (!rst_n) // R8
        ptr_hit && auto_speed_switch |=> spd_q)
        else $error("pointer activity gave no boost");
    AST_TIM_READ: assert property (@(posedge core_clk) disable iff (!rst_n) // R13
        io_rd && !io_wr && io_addr == `BSD_TIM_ADDR |=> rdata_q == $past(tim_q))
        else $error("timing register readback wrong");
endmodule
`default_nettype wire

/* dv/bsd_dram_model.sv */
// far-side model: reference clock source and DRAM strobe timer
`timescale 1ns/1ps
`default_nettype none
module bsd_dram_model (
    input wire logic core_clk,
    input wire logic ras_n,
    input wire logic cas_n,
    output logic ref_clk,
    output logic [7:0] ras_cas_gap,
    output logic [7:0] cas_width
);
    logic ras_q = 1'b1;
    logic cas_q = 1'b1;
    logic cas_seen = 1'b1;
    // free-running reference for the delay-line tuner
    initial begin
        ref_clk = 1'b0;
        forever #34.92 ref_clk = ~ref_clk;
    end
    // strobe timing as the DRAM sees it, in core clocks
    always @(posedge core_clk) begin
        ras_q <= ras_n;
        cas_q <= cas_n;
        if (ras_q === 1'b1 && ras_n === 1'b0) begin
            ras_cas_gap <= 8'h01;
            cas_seen <= 1'b0;
        end else if (ras_n === 1'b0 && cas_n === 1'b1 && !cas_seen) begin
            ras_cas_gap <= ras_cas_gap + 8'h01;
        end
        if (cas_q === 1'b1 && cas_n === 1'b0) begin
            cas_width <= 8'h01;
            cas_seen <= 1'b1;
        end else if (cas_n === 1'b0) begin
            cas_width <= cas_width + 8'h01;
        end
    end
endmodule
`default_nettype wire

/* dv/bios_shadow_dram_timing_test.sv */
// self-checking bench for the memory map and non-page timing block
`timescale 1ns/1ps
`default_nettype none
`include "bsd_regs.svh"
module bios_shadow_dram_timing_test;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic io_wr = 1'b0, io_rd = 1'b0, mem_start = 1'b0, mem_write = 1'b0, mem_ems = 1'b0, auto_sw = 1'b1;
    logic dma = 1'b0, ilv = 1'b0, ptr_act;
    logic [15:0] io_addr = 16'h0000, io_wdata = 16'h0000, io_rdata;
    logic [24:0] mem_addr = 25'h0000000;
    logic [2:0] ptr_irq = 3'h0;
    logic [4:0] rom_cs;
    logic exp_sel, dram_sel, wr_blk, ras_n, cas_n, done, boost, ref_clk;
    logic [2:0] waits;
    logic [7:0] gap, cwid;
    int failures = 0;
    int checks_done = 0;

    // short boost count keeps the run brief
    bsd_memctl #(.BOOST_CYCLES(50)) i_dut (.core_clk(core_clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .mem_start(mem_start), .mem_addr(mem_addr),
        .mem_write(mem_write), .mem_dma(dma), .mem_ems(mem_ems), .mem_ilv_miss(ilv), .pointer_irq(ptr_irq),
        .auto_speed_switch(auto_sw), .reference_14m_clock(ref_clk), .rom_chip_select(rom_cs),
        .expansion_select(exp_sel), .dram_select(dram_sel), .write_blocked(wr_blk), .ras_n(ras_n),
        .cas_n(cas_n), .cycle_done(done), .wait_states(waits), .speed_boost(boost), .pointer_activity(ptr_act));
    bsd_dram_model i_dram (.core_clk(core_clk), .ras_n(ras_n), .cas_n(cas_n), .ref_clk(ref_clk),
        .ras_cas_gap(gap), .cas_width(cwid));

    // 40 MHz core clock
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic io_w(input logic [15:0] a, input logic [15:0] d);
        @(posedge core_clk);
        io_wr <= 1'b1;
        io_addr <= a;
        io_wdata <= d;
        @(posedge core_clk);
        io_wr <= 1'b0;
    endtask

    // read data lands one cycle after the request edge
    task automatic io_r(input logic [15:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        io_rd <= 1'b1;
        io_addr <= a;
        @(posedge core_clk);
        io_rd <= 1'b0;
        #1;
        check("io_rdata", io_rdata, exp);
    endtask

    // one memory cycle; waits for the done pulse under a bound
    task automatic mem(input logic [24:0] a, input logic wr, input logic ems);
        @(posedge core_clk);
        mem_start <= 1'b1;
        mem_addr <= a;
        mem_write <= wr;
        mem_ems <= ems;
        @(posedge core_clk);
        mem_start <= 1'b0;
        #1;
        for (int i = 0; i < 400 && done !== 1'b1; i++) begin
            @(posedge core_clk);
            #1;
        end
        if (done !== 1'b1) begin
            failures++;
            $display("[ERR] cycle_done expected 1 seen %b", done);
            wrap_up();
        end
    endtask

    task automatic rom_at(input logic [15:0] bios_shadow_select, input logic [24:0] a, input logic [4:0] exp);
        io_w(`BSD_SHD_ADDR, bios_shadow_select);
        mem(a, 1'b0, 1'b0);
        check("rom_chip_select", 16'(rom_cs), 16'(exp));
    endtask

    task automatic t_regs();
        io_r(`BSD_TIM_ADDR, 16'h0000);
        io_r(`BSD_SHD_ADDR, 16'h0004);
        io_r(`BSD_BND_ADDR, 16'h0000);
        io_w(`BSD_TIM_ADDR, 16'hffff);
        io_r(`BSD_TIM_ADDR, 16'h7f7f);
        io_w(`BSD_BND_ADDR, 16'hffff);
        io_r(`BSD_BND_ADDR, 16'h00ff);
        io_w(16'h8072, 16'hffff);
        io_r(16'h8072, 16'h0000);
        io_w(`BSD_TIM_ADDR, 16'h0000);
    endtask

    task automatic t_rom();
        rom_at(16'h0000, 25'h00e0000, 5'h00);
        rom_at(16'h0000, 25'h0fe0000, 5'h00);
        rom_at(16'h0004, 25'h00e0000, 5'h1f);
        rom_at(16'h0004, 25'h00f0000, 5'h00);
        rom_at(16'h0018, 25'h00c7ffe, 5'h00);
        rom_at(16'h0018, 25'h00c8000, 5'h1f);
        rom_at(16'h0018, 25'h0ff0000, 5'h00);
        rom_at(16'h0038, 25'h00cfffe, 5'h00);
        rom_at(16'h000c, 25'h00f0000, 5'h1f);
        rom_at(16'h0318, 25'h00e0000, 5'h1f);
        check("expansion_select", 16'(exp_sel), 16'h0001);
        rom_at(16'h0394, 25'h00e8000, 5'h1f);
        check("spare_ram", 16'(dram_sel), 16'h0001);
    endtask

    task automatic t_prot();
        io_w(`BSD_BND_ADDR, 16'h0010);
        io_w(`BSD_SHD_ADDR, 16'h2004);
        mem(25'h0200000, 1'b1, 1'b0);
        check("blocked_hi", 16'(wr_blk), 16'h0001);
        mem(25'h01ffffe, 1'b1, 1'b0);
        check("blocked_lo", 16'(wr_blk), 16'h0000);
        io_w(`BSD_SHD_ADDR, 16'h0004);
        mem(25'h0200000, 1'b1, 1'b0);
        check("blocked_off", 16'(wr_blk), 16'h0000);
    endtask

    // strobe spacing per CAS-delay code, timing applied right after the write
    task automatic t_timing();
        for (int k = 0; k < 4; k++) begin
            io_w(`BSD_TIM_ADDR, 16'(k << 10));
            mem(25'h0001000, 1'b1, 1'b0);
            check("cas_delay_wr", 16'(gap), 16'(2 + k));
            check("cas_width_wr", 16'(cwid), 16'(4 - (k % 2)));
        end
        io_w(`BSD_TIM_ADDR, 16'h001c);
        mem(25'h0001000, 1'b1, 1'b0);
        check("cas_width_ext", 16'(cwid), 16'h000b);
        io_w(`BSD_TIM_ADDR, 16'h0300);
        mem(25'h0001000, 1'b0, 1'b0);
        check("cas_delay_rd", 16'(gap), 16'h0005);
        check("cas_width_rd", 16'(cwid), 16'h0003);
        check("raw_wait", 16'(waits), 16'h0002);
        io_w(`BSD_TIM_ADDR, 16'h1003);
        mem(25'h0001000, 1'b1, 1'b0);
        mem(25'h0001000, 1'b0, 1'b0);
        check("added_waits", 16'(waits), 16'h0004);
        mem(25'h0001000, 1'b0, 1'b1);
        check("ems_wait", 16'(waits), 16'h0005);
        io_w(`BSD_TIM_ADDR, 16'h3000);
        mem(25'h0001000, 1'b0, 1'b0);
        check("mode01_waits", 16'(waits), 16'h0000);
    endtask

    // dma strobes follow the tuned delay line, 2 or 3 reference-measured clocks doubled
    task automatic t_dma();
        @(posedge core_clk);
        dma <= 1'b1;
        mem(25'h0001000, 1'b0, 1'b0);
        check("dma_waits", 16'(waits), 16'h0000);
        check("dma_cas_delay", 16'(gap > 8'h03 && gap < 8'h07), 16'h0001);
        @(posedge core_clk);
        dma <= 1'b0;
        ilv <= 1'b1;
        mem(25'h0001000, 1'b0, 1'b0);
        check("ilv_wait", 16'(waits), 16'h0001);
        @(posedge core_clk);
        ilv <= 1'b0;
    endtask

    // choices 01-11 each raise activity on their own line; choice 00 ignores all three lines
    task automatic t_boost();
        for (int c = 0; c < 4; c++) begin
            io_w(`BSD_SHD_ADDR, 16'h0004 | 16'(c));
            @(posedge core_clk);
            ptr_irq <= (c == 0) ? 3'h7 : 3'(1 << (c - 1));
            @(posedge core_clk);
            ptr_irq <= 3'h0;
            #1;
            check("ptr_activity", 16'(ptr_act), 16'(c != 0));
            repeat (5) @(posedge core_clk);
            #1;
            check("boost_on", 16'(boost), 16'(c != 0));
            repeat (60) @(posedge core_clk);
            #1;
            check("boost_off", 16'(boost), 16'h0000);
        end
        // no boost while auto speed switching is off
        io_w(`BSD_SHD_ADDR, 16'h0005);
        @(posedge core_clk);
        auto_sw <= 1'b0;
        ptr_irq <= 3'h1;
        @(posedge core_clk);
        ptr_irq <= 3'h0;
        #1;
        check("ptr_activity_off", 16'(ptr_act), 16'h0001);
        repeat (5) @(posedge core_clk);
        #1;
        check("boost_auto_off", 16'(boost), 16'h0000);
    endtask

    initial begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        t_regs();
        t_rom();
        t_prot();
        t_timing();
        t_dma();
        t_boost();
        wrap_up();
    end
endmodule
`default_nettype wire
